// file: rtl/timer_unit.sv
// Modulo timer with one channel, APB register slave
//
// How it works
// - Clock source field: 00 stops, 01 bus, 10 fixed clock, 11 external.
// - Prescale field divides selected clock by 1 up to 128.
// - Reading either count byte latches both until the other is read.
// - Count latch released by reset or any status/control write.
// - Reset clears count; writing either count byte clears count and latch.
// - Debug halt freezes the count and the read latch state.
// - In debug halt, status/control or count writes still release latch.
// - Center-aligned off: at wrap limit the next tick returns count to zero, sets overflow flag.
// - Overflow flag suppressed between first and second wrap limit byte write.
// - Reset wrap limit is zero: free-running full 16-bit count.
// - Wrap writes are buffered; with no clock, applied at second byte.
// - With clock, wrap applied on step limit-1 to limit, or 0xfffe to 0xffff.
// - Status/control write discards a partial wrap limit write.
// - In debug halt wrap buffer frozen; writes go straight to active limit.
// - Channel flag set on capture edge, or on count match in compare/PWM.
// - No channel flag in PWM at 0% or 100% duty.
// - Channel interrupt while channel flag and channel enable are set.
// - Channel flag cleared by read-while-set then write zero; new event wins.
// - Writing one to channel flag does nothing; reset clears flag, enable.
// - Mode B bit with center-aligned off selects edge-aligned PWM.
// - Overflow flag cleared by read-while-set then write zero; new overflow wins.
// - Center-aligned select makes count up/down, all channels center PWM.
// - Overflow interrupt while overflow flag and its enable are set.
// - New prescale takes effect from the next clock cycle.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module timer_unit #(
   parameter int PRESCALE_BITS = 7
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Clock sources and pins (asynchronous)
   input  wire logic        fixed_clk_in,
   input  wire logic        ext_clk_in,
   input  wire logic        channel_pin_in,
   output logic             channel_pin_out,
   output logic             channel_pin_oe,
   // Interrupt requests
   output logic             overflow_irq,
   output logic             channel_irq
);
   // Mask logic assumes the seven-bit divide chain of the prescale field
   if (PRESCALE_BITS != 7) begin : g_bad_prescale
      $error("PRESCALE_BITS must be 7");
   end

   // Bus decode
   wire logic wr_en  = psel & penable & pwrite;
   wire logic rd_su  = psel & ~penable & ~pwrite;
   wire logic a_sc   = paddr == timer_unit_pkg::ADDR_STATUS_CONTROL;
   wire logic a_chi  = paddr == timer_unit_pkg::ADDR_COUNT_HI;
   wire logic a_clo  = paddr == timer_unit_pkg::ADDR_COUNT_LO;
   wire logic a_whi  = paddr == timer_unit_pkg::ADDR_WRAP_LIMIT_HI;
   wire logic a_wlo  = paddr == timer_unit_pkg::ADDR_WRAP_LIMIT_LO;
   wire logic a_cc   = paddr == timer_unit_pkg::ADDR_CHANNEL_CTRL;
   wire logic a_cv   = paddr == timer_unit_pkg::ADDR_CHANNEL_VALUE;
   wire logic a_dbg  = paddr == timer_unit_pkg::ADDR_DEBUG_CTRL;
   wire logic mapped = a_sc | a_chi | a_clo | a_whi | a_wlo | a_cc | a_cv | a_dbg;
   wire logic w_sc   = wr_en & a_sc;
   wire logic w_cnt  = wr_en & (a_chi | a_clo);
   wire logic w_whi  = wr_en & a_whi;
   wire logic w_wlo  = wr_en & a_wlo;
   wire logic w_cc   = wr_en & a_cc;
   // Reads act in setup, where read data is captured, so latch and data agree
   wire logic r_cnt  = rd_su & (a_chi | a_clo);

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Registers
   logic [15:0] count_ff, wrap_ff, wrap_buf_ff, cnt_latch_ff, chan_val_ff;
   logic        ovf_ff, ovie_ff, cpwm_ff, down_ff;
   logic [1:0]  clks_ff;
   logic [2:0]  ps_ff;
   logic        chf_ff, chie_ff, msb_ff, msa_ff, elsb_ff, elsa_ff;
   logic        debug_ff;
   logic        cnt_latched_ff, cnt_latch_hi_ff;
   logic        wrap_hi_done_ff, wrap_lo_done_ff;
   logic        ovf_armed_ff, chf_armed_ff;
   logic [PRESCALE_BITS-1:0] psc_ff;
   logic [1:0]  fix_sync_ff, ext_sync_ff, pin_sync_ff;
   logic        fix_prev_ff, ext_prev_ff, pin_prev_ff;
   logic        pin_out_ff;
   logic [31:0] prdata_ff;

   // Source selection with synchronised edges
   wire logic fix_edge = fix_sync_ff[1] & ~fix_prev_ff;
   wire logic ext_edge = ext_sync_ff[1] & ~ext_prev_ff;
   wire logic src_tick = (clks_ff == timer_unit_pkg::CLKS_BUS)   ? 1'b1     :
                         (clks_ff == timer_unit_pkg::CLKS_FIXED) ? fix_edge :
                         (clks_ff == timer_unit_pkg::CLKS_EXT)   ? ext_edge : 1'b0;
   wire logic run = src_tick & ~debug_ff;
   // Prescaler output: all low bits below the chosen power set
   wire logic [PRESCALE_BITS-1:0] psc_mask = PRESCALE_BITS'((1 << ps_ff) - 1);
   wire logic tick = run & ((psc_ff & psc_mask) == psc_mask);
   wire logic [PRESCALE_BITS-1:0] nxt_psc = tick ? '0 : (run ? psc_ff + 1'b1 : psc_ff);

   // Counting
   wire logic free_run = wrap_ff == timer_unit_pkg::WRAP_RESET;
   wire logic [15:0] limit = free_run ? timer_unit_pkg::COUNT_TOP : wrap_ff;
   wire logic at_limit = count_ff == limit;
   wire logic at_zero  = count_ff == timer_unit_pkg::COUNT_RESET;
   wire logic wrap_both = wrap_hi_done_ff & wrap_lo_done_ff;
   wire logic up_ovf   = ~cpwm_ff & at_limit;
   wire logic dn_ovf   = cpwm_ff & down_ff & at_zero & ~at_limit;
   // Overflow held off while only one wrap byte has been written
   wire logic free_run_suppress = wrap_hi_done_ff ^ wrap_lo_done_ff;
   wire logic ovf_event = tick & (up_ovf | dn_ovf) & ~free_run_suppress;
   wire logic [15:0] step_up = count_ff + timer_unit_pkg::COUNT_ONE;
   wire logic [15:0] step_dn = count_ff - timer_unit_pkg::COUNT_ONE;
   logic [15:0] nxt_count;
   logic        nxt_down;
   always_comb begin
      nxt_count = count_ff;
      nxt_down  = down_ff;
      if (w_cnt) begin
         nxt_count = timer_unit_pkg::COUNT_RESET;
         nxt_down  = 1'b0;
      end else if (tick) begin
         if (!cpwm_ff) begin
            nxt_count = at_limit ? timer_unit_pkg::COUNT_RESET : step_up;
         end else if (!down_ff) begin
            nxt_count = at_limit ? step_dn : step_up;
            nxt_down  = at_limit;
         end else begin
            nxt_count = at_zero ? step_up : step_dn;
            nxt_down  = ~at_zero;
         end
      end
   end
   // Buffered limit lands as the count steps onto the limit
   wire logic wrap_apply_run = tick & wrap_both & (step_up == limit) & ~down_ff;
   wire logic wrap_apply_idle = (clks_ff == timer_unit_pkg::CLKS_NONE) & wrap_both;

   // Channel
   wire logic edge_pwm  = ~cpwm_ff & msb_ff;
   wire logic pwm_mode  = edge_pwm | cpwm_ff;
   wire logic capture   = ~cpwm_ff & ~msb_ff & ~msa_ff;
   wire logic pin_rise  = pin_sync_ff[1] & ~pin_prev_ff;
   wire logic pin_fall  = ~pin_sync_ff[1] & pin_prev_ff;
   wire logic cap_event = capture & ((elsa_ff & pin_rise) | (elsb_ff & pin_fall));
   wire logic duty_edge = (chan_val_ff == timer_unit_pkg::COUNT_RESET)
                        | (chan_val_ff > limit);
   wire logic cmp_event = ~capture & tick & (count_ff == chan_val_ff)
                        & ~(pwm_mode & duty_edge);
   wire logic ch_event  = cap_event | cmp_event;

   // Pin output for compare and PWM
   logic nxt_pin_out;
   always_comb begin
      nxt_pin_out = pin_out_ff;
      if (cpwm_ff && tick && count_ff == chan_val_ff) begin
         nxt_pin_out = down_ff ^ elsa_ff;
      end else if (edge_pwm && tick && at_limit) begin
         nxt_pin_out = ~elsa_ff;
      end else if (cmp_event && !pwm_mode) begin
         nxt_pin_out = (elsb_ff & elsa_ff) | (~elsb_ff & ~pin_out_ff);
      end else if (cmp_event && edge_pwm) begin
         nxt_pin_out = elsa_ff;
      end
   end

   // Read mux
   wire logic [15:0] cnt_view = (cnt_latched_ff && !debug_ff) ? cnt_latch_ff : count_ff;
   wire logic [7:0] sc_view = {ovf_ff, ovie_ff, cpwm_ff, clks_ff, ps_ff};
   wire logic [7:0] cc_view = {chf_ff, chie_ff, msb_ff, msa_ff, elsb_ff, elsa_ff, 2'b00};
   wire logic [31:0] rd_word =
      a_sc  ? {24'h000000, sc_view}        :
      a_chi ? {24'h000000, cnt_view[15:8]} :
      a_clo ? {24'h000000, cnt_view[7:0]}  :
      a_whi ? {24'h000000, wrap_ff[15:8]}  :
      a_wlo ? {24'h000000, wrap_ff[7:0]}   :
      a_cc  ? {24'h000000, cc_view}        :
      a_cv  ? {16'h0000, chan_val_ff}      :
      a_dbg ? {31'h00000000, debug_ff}     : timer_unit_pkg::WORD_ZERO;

   // Sync and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fix_sync_ff <= 2'h0;
         ext_sync_ff <= 2'h0;
         pin_sync_ff <= 2'h0;
         fix_prev_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
         pin_prev_ff <= 1'b0;
         psc_ff      <= '0;
      end else begin
         fix_sync_ff <= {fix_sync_ff[0], fixed_clk_in};
         ext_sync_ff <= {ext_sync_ff[0], ext_clk_in};
         pin_sync_ff <= {pin_sync_ff[0], channel_pin_in};
         fix_prev_ff <= fix_sync_ff[1];
         ext_prev_ff <= ext_sync_ff[1];
         pin_prev_ff <= pin_sync_ff[1];
         psc_ff      <= nxt_psc;
      end
   end

   // Counter and status/control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= timer_unit_pkg::COUNT_RESET;
         down_ff  <= 1'b0;
         ovf_ff   <= 1'b0;
         ovf_armed_ff <= 1'b0;
         ovie_ff  <= 1'b0;
         cpwm_ff  <= 1'b0;
         clks_ff  <= timer_unit_pkg::CLKS_NONE;
         ps_ff    <= 3'h0;
         debug_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         down_ff  <= nxt_down;
         if (rd_su && a_sc) ovf_armed_ff <= ovf_ff;
         // Set beats clear; a fresh overflow also disarms the clear
         if (ovf_event) begin
            ovf_ff       <= 1'b1;
            ovf_armed_ff <= 1'b0;
         end else if (w_sc && ovf_armed_ff && !pwdata[timer_unit_pkg::OVF_BIT]) begin
            ovf_ff       <= 1'b0;
            ovf_armed_ff <= 1'b0;
         end
         if (w_sc) begin
            ovie_ff <= pwdata[timer_unit_pkg::OVIE_BIT];
            cpwm_ff <= pwdata[timer_unit_pkg::CPWM_BIT];
            clks_ff <= pwdata[timer_unit_pkg::CLKS_HI:timer_unit_pkg::CLKS_LO];
            ps_ff   <= pwdata[timer_unit_pkg::PS_HI:timer_unit_pkg::PS_LO];
         end
         if (wr_en && a_dbg) debug_ff <= pwdata[0];
      end
   end

   // Count read latch and wrap limit buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_latched_ff  <= 1'b0;
         cnt_latch_hi_ff <= 1'b0;
         cnt_latch_ff    <= timer_unit_pkg::COUNT_RESET;
         wrap_ff         <= timer_unit_pkg::WRAP_RESET;
         wrap_buf_ff     <= timer_unit_pkg::WRAP_RESET;
         wrap_hi_done_ff <= 1'b0;
         wrap_lo_done_ff <= 1'b0;
      end else begin
         if (w_sc || w_cnt) begin
            cnt_latched_ff <= 1'b0;
         end else if (r_cnt && !debug_ff) begin
            if (!cnt_latched_ff) begin
               cnt_latched_ff  <= 1'b1;
               cnt_latch_ff    <= count_ff;
               cnt_latch_hi_ff <= a_chi;
            end else if (cnt_latch_hi_ff != a_chi) begin
               cnt_latched_ff <= 1'b0;
            end
         end
         if (w_sc) begin
            wrap_hi_done_ff <= 1'b0;
            wrap_lo_done_ff <= 1'b0;
         end else if (debug_ff) begin
            if (w_whi) wrap_ff[15:8] <= pwdata[7:0];
            if (w_wlo) wrap_ff[7:0]  <= pwdata[7:0];
         end else if (wrap_apply_idle || wrap_apply_run) begin
            wrap_ff         <= wrap_buf_ff;
            wrap_hi_done_ff <= 1'b0;
            wrap_lo_done_ff <= 1'b0;
         end else begin
            if (w_whi) begin
               wrap_buf_ff[15:8] <= pwdata[7:0];
               wrap_hi_done_ff   <= 1'b1;
            end
            if (w_wlo) begin
               wrap_buf_ff[7:0] <= pwdata[7:0];
               wrap_lo_done_ff  <= 1'b1;
            end
         end
      end
   end

   // Channel registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chf_ff       <= 1'b0;
         chie_ff      <= 1'b0;
         chf_armed_ff <= 1'b0;
         msb_ff       <= 1'b0;
         msa_ff       <= 1'b0;
         elsb_ff      <= 1'b0;
         elsa_ff      <= 1'b0;
         chan_val_ff  <= timer_unit_pkg::COUNT_RESET;
         pin_out_ff   <= 1'b0;
      end else begin
         pin_out_ff <= nxt_pin_out;
         if (rd_su && a_cc) chf_armed_ff <= chf_ff;
         if (ch_event) begin
            chf_ff       <= 1'b1;
            chf_armed_ff <= 1'b0;
         end else if (w_cc && chf_armed_ff && !pwdata[timer_unit_pkg::CHF_BIT]) begin
            chf_ff       <= 1'b0;
            chf_armed_ff <= 1'b0;
         end
         if (w_cc) begin
            chie_ff <= pwdata[timer_unit_pkg::CHIE_BIT];
            msb_ff  <= pwdata[timer_unit_pkg::MSB_BIT];
            msa_ff  <= pwdata[timer_unit_pkg::MSA_BIT];
            elsb_ff <= pwdata[timer_unit_pkg::ELSB_BIT];
            elsa_ff <= pwdata[timer_unit_pkg::ELSA_BIT];
         end
         if (cap_event) begin
            chan_val_ff <= count_ff;
         end else if (wr_en && a_cv && !capture) begin
            chan_val_ff <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= timer_unit_pkg::WORD_ZERO;
      end else if (rd_su) begin
         prdata_ff <= rd_word;
      end
   end

   // Setup-phase capture keeps read data stable through the access phase
   assign prdata          = prdata_ff;
   assign overflow_irq    = ovf_ff & ovie_ff;
   assign channel_irq     = chf_ff & chie_ff;
   assign channel_pin_out = pin_out_ff;
   assign channel_pin_oe  = ~capture & (elsb_ff | elsa_ff);
endmodule

// file: shared/timer_unit_pkg.sv
// Register map, field layout and constants of the modulo timer
package timer_unit_pkg;
   // Register byte addresses (one aligned word each)
   localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_COUNT_HI       = 8'h04;
   localparam logic [7:0] ADDR_COUNT_LO       = 8'h08;
   localparam logic [7:0] ADDR_WRAP_LIMIT_HI  = 8'h0c;
   localparam logic [7:0] ADDR_WRAP_LIMIT_LO  = 8'h10;
   localparam logic [7:0] ADDR_CHANNEL_CTRL   = 8'h14;
   localparam logic [7:0] ADDR_CHANNEL_VALUE  = 8'h18;
   localparam logic [7:0] ADDR_DEBUG_CTRL     = 8'h1c;

   // Status/control fields
   localparam int OVF_BIT  = 7;
   localparam int OVIE_BIT = 6;
   localparam int CPWM_BIT = 5;
   localparam int CLKS_HI  = 4;
   localparam int CLKS_LO  = 3;
   localparam int PS_HI    = 2;
   localparam int PS_LO    = 0;

   // Channel control fields
   localparam int CHF_BIT  = 7;
   localparam int CHIE_BIT = 6;
   localparam int MSB_BIT  = 5;
   localparam int MSA_BIT  = 4;
   localparam int ELSB_BIT = 3;
   localparam int ELSA_BIT = 2;

   // Clock source codes
   localparam logic [1:0] CLKS_NONE  = 2'h0;
   localparam logic [1:0] CLKS_BUS   = 2'h1;
   localparam logic [1:0] CLKS_FIXED = 2'h2;
   localparam logic [1:0] CLKS_EXT   = 2'h3;

   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] WRAP_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_TOP   = 16'hffff;
   localparam logic [15:0] COUNT_ONE   = 16'h0001;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
endpackage

// file: bench/timer_unit_checker.sv
// Bus and interrupt checker for the modulo timer
`timescale 1ns/100ps
module timer_unit_checker (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Pin and interrupts
   input wire logic        channel_pin_oe,
   input wire logic        overflow_irq,
   input wire logic        channel_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc   = psel && penable;
   wire unmap = paddr[1:0] != 2'h0 || paddr > 8'h1c;
   wire rd_su = psel && !penable && !pwrite;
   wire wr_sc = acc && pwrite && paddr == timer_unit_pkg::ADDR_STATUS_CONTROL;
   wire wr_ch = acc && pwrite && paddr == timer_unit_pkg::ADDR_CHANNEL_CTRL;

   AST_READY: assert property (pready) else $error("pready low");
   AST_SLVERR: assert property (acc |-> pslverr == unmap) else $error("pslverr wrong");
   AST_PRDATA_HOLD: assert property (!rd_su |=> $stable(prdata)) else $error("prdata moved");
   AST_UNMAP_ZERO: assert property (rd_su && unmap |=> prdata == 32'h0) else $error("bad read");
   AST_OVF_HOLD: assert property (overflow_irq && !wr_sc |=> overflow_irq)
      else $error("overflow request dropped");
   AST_OVF_OFF: assert property (wr_sc && !pwdata[6] |=> !overflow_irq)
      else $error("overflow request while disabled");
   AST_CH_HOLD: assert property (channel_irq && !wr_ch |=> channel_irq)
      else $error("channel request dropped");
   AST_CH_OFF: assert property (wr_ch && !pwdata[6] |=> !channel_irq)
      else $error("channel request while disabled");
   AST_CH_ONE: assert property (wr_ch && pwdata[7:6] == 2'h3 && channel_irq |=> channel_irq)
      else $error("writing one cleared flag");
   AST_PWM_OE: assert property (wr_ch && pwdata[5] && pwdata[3:2] != 2'h0 |=> channel_pin_oe)
      else $error("pwm pin not driven");
   AST_RESET_IRQ: assert property (disable iff (1'b0) !presetn |-> !overflow_irq && !channel_irq)
      else $error("request during reset");
endmodule

bind timer_unit timer_unit_checker u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .channel_pin_oe(channel_pin_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq)
);

// file: bench/timer_unit_test.sv
// Self-checking bench for the modulo timer
`timescale 1ns/100ps
module timer_unit_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        fixed_clk_in = 1'b0;
   logic        ext_clk_in = 1'b0;
   logic        channel_pin_in = 1'b0;
   wire logic   pready, pslverr, channel_pin_out, channel_pin_oe, overflow_irq, channel_irq;
   wire logic [31:0] prdata;
   logic [31:0] q;
   logic        err;
   int          failures = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          t_set;
   int          seed = 32'h47fe475f;

   timer_unit timer_unit_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .fixed_clk_in(fixed_clk_in), .ext_clk_in(ext_clk_in), .channel_pin_in(channel_pin_in),
      .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
      .overflow_irq(overflow_irq), .channel_irq(channel_irq)
   );

   always #12.5 pclk = ~pclk;
   // Slow sources: fixed rises every 8 cycles, external every 10
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 0) fixed_clk_in <= ~fixed_clk_in;
      if (cyc % 5 == 0) ext_clk_in <= ~ext_clk_in;
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Counts seen through clock sync carry a few cycles of slack
   task automatic near(input logic [31:0] got, input int exp, input int tol, input string m);
      int d;
      n_tests++;
      d = int'(got) - exp;
      if (^got === 1'bx || d > tol || d < -tol) begin
         failures++;
         $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      t_set = cyc;
      penable <= 1'b1;
      // Waits as long as the slave wants; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic rd16(output logic [31:0] c);
      logic [7:0] l;
      int t0;
      rd(timer_unit_pkg::ADDR_COUNT_LO);
      l = q[7:0];
      t0 = t_set;
      rd(timer_unit_pkg::ADDR_COUNT_HI);
      c = {16'h0, q[7:0], l};
      t_set = t0;
   endtask

   task automatic wait_ovf(output int n);
      n = 0;
      while (overflow_irq !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
   endtask

   initial begin
      int lim, st, v, div;
      logic [31:0] c;
      logic [7:0] sc;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a < 6; a++) begin
         rd(8'(a * 4) + ((a == 5) ? 8'h00 : 8'h00) + ((a == 5) ? 8'h00 : 8'h00));
         chk(q, 32'h0, "reset value");
      end
      rd(8'h20);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(q, 32'h0, "unmapped data");
      $display("test reset done");
      for (int i = 0; i < 11; i++) begin
         sc = (i < 4) ? 8'(i << 3) : 8'(8'h08 | (i - 3));
         div = (i == 0) ? 0 : (i == 2) ? 8 : (i == 3) ? 10 : (i < 4) ? 1 : (1 << (i - 3));
         wr(timer_unit_pkg::ADDR_COUNT_LO, 32'h0);
         wr(timer_unit_pkg::ADDR_STATUS_CONTROL, {24'h0, sc});
         st = cyc;
         repeat (1000) @(posedge pclk);
         wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h0);
         v = (div == 0) ? 0 : (t_set - st + 2) / div;
         rd16(c);
         near(c, v, 4, "count rate");
      end
      $display("test clock and prescale done");
      wr(timer_unit_pkg::ADDR_COUNT_LO, 32'h0);
      wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h08);
      st = cyc;
      repeat (100) @(posedge pclk);
      rd(timer_unit_pkg::ADDR_COUNT_HI);
      v = t_set - st;
      chk(q, 32'h0, "count hi");
      repeat (300) @(posedge pclk);
      rd(timer_unit_pkg::ADDR_COUNT_LO);
      near(q, v & 255, 4, "latched lo");
      rd(timer_unit_pkg::ADDR_COUNT_LO);
      v = t_set - st;
      repeat (300) @(posedge pclk);
      rd(timer_unit_pkg::ADDR_COUNT_HI);
      chk(q, 32'(v >> 8), "latched hi");
      rd(timer_unit_pkg::ADDR_COUNT_LO);
      wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h08);
      repeat (200) @(posedge pclk);
      rd(timer_unit_pkg::ADDR_COUNT_HI);
      chk(q, 32'((t_set - st) >> 8), "released hi");
      wr(timer_unit_pkg::ADDR_DEBUG_CTRL, 32'h1);
      wr(timer_unit_pkg::ADDR_COUNT_LO, 32'h5a);
      repeat (50) @(posedge pclk);
      rd16(c);
      chk(c, 32'h0, "frozen count");
      wr(timer_unit_pkg::ADDR_DEBUG_CTRL, 32'h0);
      st = cyc;
      repeat (100) @(posedge pclk);
      rd16(c);
      near(c, t_set - st + 1, 4, "count resumes");
      $display("test coherency done");
      for (int n = 0; n < 3; n++) begin
         lim = 4 + $unsigned($random(seed)) % 16;
         wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h0);
         wr(timer_unit_pkg::ADDR_COUNT_LO, 32'h0);
         wr(timer_unit_pkg::ADDR_WRAP_LIMIT_HI, 32'h0);
         wr(timer_unit_pkg::ADDR_WRAP_LIMIT_LO, 32'(lim));
         wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h48);
         wait_ovf(v);
         near(v, lim, 3, "first overflow");
         wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'hc0);
         chk({31'h0, overflow_irq}, 32'h1, "flag after write one");
         rd(timer_unit_pkg::ADDR_STATUS_CONTROL);
         chk(q, 32'hc0, "status with flag");
         wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h40);
         chk({31'h0, overflow_irq}, 32'h0, "flag cleared");
         rd16(c);
         chk({31'h0, c <= 32'(lim)}, 32'h1, "count within limit");
      end
      wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h48);
      wr(timer_unit_pkg::ADDR_WRAP_LIMIT_HI, 32'h0);
      repeat (3 * lim) @(posedge pclk);
      chk({31'h0, overflow_irq}, 32'h0, "overflow suppressed");
      wr(timer_unit_pkg::ADDR_WRAP_LIMIT_LO, 32'(lim));
      wait_ovf(v);
      chk({31'h0, v <= 2 * lim + 8}, 32'h1, "overflow returns");
      wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h08);
      $display("test overflow done");
      wr(timer_unit_pkg::ADDR_CHANNEL_CTRL, 32'h04);
      chk({31'h0, channel_pin_oe}, 32'h0, "capture pin not driven");
      channel_pin_in <= 1'b1;
      repeat (10) @(posedge pclk);
      chk({31'h0, channel_irq}, 32'h0, "masked channel");
      wr(timer_unit_pkg::ADDR_CHANNEL_CTRL, 32'hc4);
      chk({31'h0, channel_irq}, 32'h1, "capture flag");
      wr(timer_unit_pkg::ADDR_CHANNEL_CTRL, 32'h44);
      chk({31'h0, channel_irq}, 32'h1, "clear without read");
      wr(timer_unit_pkg::ADDR_CHANNEL_CTRL, 32'hc4);
      chk({31'h0, channel_irq}, 32'h1, "write one keeps flag");
      rd(timer_unit_pkg::ADDR_CHANNEL_CTRL);
      chk(q, 32'hc4, "channel status");
      wr(timer_unit_pkg::ADDR_CHANNEL_CTRL, 32'h44);
      chk({31'h0, channel_irq}, 32'h0, "flag cleared");
      // Count stopped so no match can flag before the value is set
      wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h0);
      wr(timer_unit_pkg::ADDR_CHANNEL_CTRL, 32'h28);
      chk({31'h0, channel_pin_oe}, 32'h1, "pwm drives pin");
      wr(timer_unit_pkg::ADDR_CHANNEL_VALUE, 32'h0);
      wr(timer_unit_pkg::ADDR_STATUS_CONTROL, 32'h08);
      repeat (2 * lim + 4) @(posedge pclk);
      rd(timer_unit_pkg::ADDR_CHANNEL_CTRL);
      chk(q, 32'h28, "no flag at zero duty");
      wr(timer_unit_pkg::ADDR_CHANNEL_VALUE, 32'(lim + 1));
      repeat (2 * lim + 4) @(posedge pclk);
      chk({31'h0, channel_pin_out}, 32'h1, "full duty pin high");
      $display("test channel done");
      summarize();
   end

   // Whole run needs about 13000 cycles
   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      summarize();
   end
endmodule
